// >>> design/cub_defs.vh
// cub_defs.vh: register map, field layout, reset values and timing counts of the unbalance stage
`ifndef CUB_DEFS_VH
`define CUB_DEFS_VH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CUB_CLK_MHZ 100
`define CUB_TICK_MS 5
`define CUB_TICK_CYC 20'h7A120 // 5 ms at 100 MHz, sized for the divider counter
`define CUB_LAST_BIT 6'h1F
// ---------------------------------------------------------------
// arithmetic scales
// ---------------------------------------------------------------
`define CUB_REL_PCT 40'h61
`define CUB_PCT_FULL 40'h64
`define CUB_RATIO_SCALE 40'h2710
// ---------------------------------------------------------------
// register word offsets
// ---------------------------------------------------------------
`define CUB_A_GCTRL 6'h00
`define CUB_A_MINLOAD 6'h01
`define CUB_A_RATIO 6'h02
`define CUB_A_LOGPTR 6'h03
`define CUB_A_FANG0 6'h04
`define CUB_A_FANG1 6'h05
`define CUB_LOG_DEPTH 4'hC
`define CUB_W_SCTRL 3'h0
`define CUB_W_NSET 3'h1
`define CUB_W_RSET 3'h2
`define CUB_W_DELAY 3'h3
`define CUB_W_STATUS 3'h4
`define CUB_W_REMAIN 3'h5
`define CUB_W_EXPECT 3'h6
`define CUB_W_MSET 3'h7
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define CUB_GC_RATIO 0
`define CUB_GC_FORCE 1
`define CUB_GC_GROUP 2
`define CUB_TM_INST 2'h0
`define CUB_TM_FIX 2'h1
`define CUB_TM_INV 2'h2
`define CUB_RST_NSET 16'h0014
`define CUB_RST_RSET 16'h07D0
`define CUB_RST_DELAY 32'h00000064
`define CUB_RST_MINLOAD 16'h000A
`endif

// >>> design/cub_top.v
// cub_top.v: four-stage current unbalance protection with Avalon-MM register access
// Operation
// - two modes: negative sequence magnitude alone, or negative to positive ratio
// - sequence magnitudes come from the sequence inputs, phase channels only feed the loading check
// - ratio mode also needs all phase fundamentals above minimum loading
// - all measured quantities are taken on the 5 ms time base
// - zero sequence and angles are only captured for fault recording
// - force status overrides condition, default normal, only with global forcing on
// - magnitude select picks per-unit or ratio, per-unit after reset
// - force status and magnitude select ignore the setting group
// - pick-up when selected quantity exceeds its pick-up setting
// - release only below 97 percent of the setting, same in both modes
// - per-unit pick-up in 0.01 In steps, default 0.2 In
// - ratio pick-up in 0.01 percent steps, default 20 percent
// - pick-up from active setting group, switchable while running
// - condition published as normal, start, trip or blocked
// - publish negative sequence over pick-up, and negative over positive ratio
// - inverse-time expected operating time recomputed as current changes
// - remaining time to trip published and counted down while timing
// - block input sampled once at the start of each cycle
// - pick-up without block gives start and starts operate timing
// - pick-up with block gives blocked, no timing or trip
// - block arriving after start drops start and releases as on reset
// - instant mode trips in the same cycle as start
// - definite time trips after fixed delay while pick-up holds
// - four independent stages with own start, trip and blocked events
// - rolling log of the latest twelve start, trip or blocked on-events
`timescale 1ns/10ps
`include "cub_defs.vh"

// ---------------------------------------------------------------
// one protection stage
// ---------------------------------------------------------------
module cub_stage (
   input wire sys_clk,
   input wire sys_rst,
   input wire tick,
   input wire ratio_mode,
   input wire block_in,
   input wire force_en,
   input wire [1:0] force_sel,
   input wire [1:0] time_mode,
   input wire [15:0] nset,
   input wire [15:0] rset,
   input wire [31:0] delay,
   input wire [31:0] inv_time,
   input wire load_ok,
   input wire [15:0] neg,
   input wire [15:0] pos,
   output reg start_ff,
   output reg trip_ff,
   output reg blocked_ff,
   output reg [3:0] cond_ff,
   output reg [31:0] remain_ff,
   output reg [31:0] expect_ff,
   output reg [2:0] ev_ff
);
   localparam [3:0] S_NORM = 4'h1;
   localparam [3:0] S_START = 4'h2;
   localparam [3:0] S_TRIP = 4'h4;
   localparam [3:0] S_BLK = 4'h8;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [31:0] elapsed_ff;
   reg [31:0] nxt_elapsed;
   reg [3:0] nxt_cond;
   reg picked_ff;
   wire [39:0] neg_w = {24'h000000, neg};
   wire [39:0] meas = ratio_mode ? neg_w * `CUB_RATIO_SCALE : neg_w;
   wire [39:0] lim = ratio_mode ? {24'h000000, rset} * {24'h000000, pos} :
      {24'h000000, nset};
   wire above = meas > lim;
   wire below = meas * `CUB_PCT_FULL < lim * `CUB_REL_PCT;
   // loading gate avoids judging a ratio built on a near-zero denominator
   wire pick = (picked_ff ? !below : above) & (!ratio_mode | load_ok);
   wire [31:0] exp_t = (time_mode == `CUB_TM_FIX) ? delay :
      (time_mode == `CUB_TM_INV) ? inv_time : 32'h0;
   wire [31:0] el_inc = elapsed_ff + 32'h1;

   // state transitions, evaluated only on the cycle enable
   always @* begin
      nxt_state = state_ff;
      nxt_elapsed = elapsed_ff;
      case (state_ff)
         S_NORM: begin
            nxt_elapsed = 32'h0;
            if (pick) begin
               if (block_in)
                  nxt_state = S_BLK;
               else if (time_mode == `CUB_TM_INST)
                  nxt_state = S_TRIP;
               else
                  nxt_state = S_START;
            end
         end
         S_START: begin
            if (!pick || block_in) begin
               nxt_state = S_NORM;
               nxt_elapsed = 32'h0;
            end else begin
               nxt_elapsed = el_inc;
               if (el_inc >= exp_t)
                  nxt_state = S_TRIP;
            end
         end
         S_TRIP: begin
            if (!pick)
               nxt_state = S_NORM;
         end
         S_BLK: begin
            if (!pick || !block_in)
               nxt_state = S_NORM;
         end
         default: begin
            nxt_state = S_NORM;
         end
      endcase
   end

   // published condition, forcing wins when allowed
   always @* begin
      nxt_cond = state_ff;
      if (force_en)
         nxt_cond = 4'h1 << force_sel;
   end

   // stage registers
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= S_NORM;
         elapsed_ff <= 32'h0;
         picked_ff <= 1'b0;
         cond_ff <= S_NORM;
         start_ff <= 1'b0;
         trip_ff <= 1'b0;
         blocked_ff <= 1'b0;
         remain_ff <= 32'h0;
         expect_ff <= 32'h0;
         ev_ff <= 3'h0;
      end else begin
         if (tick) begin
            state_ff <= nxt_state;
            elapsed_ff <= nxt_elapsed;
            picked_ff <= pick;
            expect_ff <= exp_t;
            // remaining time only counts while the delay runs
            if (nxt_state == S_START && exp_t > nxt_elapsed)
               remain_ff <= exp_t - nxt_elapsed;
            else
               remain_ff <= 32'h0;
         end
         cond_ff <= nxt_cond;
         start_ff <= nxt_cond[1] | nxt_cond[2];
         trip_ff <= nxt_cond[2];
         blocked_ff <= nxt_cond[3];
         ev_ff <= {nxt_cond[3] & ~blocked_ff, nxt_cond[2] & ~trip_ff,
            (nxt_cond[1] | nxt_cond[2]) & ~start_ff};
      end
   end
endmodule // cub_stage

// ---------------------------------------------------------------
// top: bus slave, time base, divider, stages, log
// ---------------------------------------------------------------
module cub_top #(
   parameter [19:0] TICK_CYCLES = `CUB_TICK_CYC
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [15:0] posseq_magnitude,
   input wire [15:0] negseq_magnitude,
   input wire [15:0] zeroseq_magnitude,
   input wire [15:0] posseq_angle,
   input wire [15:0] negseq_angle,
   input wire [15:0] zeroseq_angle,
   input wire [15:0] phase_a_fundamental,
   input wire [15:0] phase_b_fundamental,
   input wire [15:0] phase_c_fundamental,
   input wire [3:0] block_in,
   output wire [3:0] stage_start,
   output wire [3:0] stage_trip,
   output wire [3:0] stage_blocked
);
   reg [19:0] div_cnt_ff;
   reg tick_ff, eval_ff;
   reg [15:0] pos_ff, neg_ff, zero_ff, pang_ff, nang_ff, zang_ff, pa_ff, pb_ff, pc_ff;
   reg [3:0] blk_ff;
   reg [2:0] gctrl_ff;
   reg [15:0] minload_ff;
   reg [3:0] sctrl_ff [0:3];
   reg [31:0] nsetw_ff [0:3];
   reg [31:0] rsetw_ff [0:3];
   reg [31:0] delay_ff [0:3];
   reg [31:0] mset_ff [0:3];
   reg [31:0] invt_ff [0:3];
   reg [31:0] ratio_ff;
   reg [31:0] log_ff [0:11];
   reg [3:0] wp_ff, lcnt_ff;
   reg [11:0] stamp_ff, pend_ff;
   reg [31:0] fang0_ff, fang1_ff;
   reg busy_ff, load_ff;
   reg [3:0] job_ff;
   reg [5:0] bit_ff;
   reg [32:0] rem_ff;
   reg [31:0] quo_ff, dvs_ff;
   reg [31:0] dvd, dvs, rdata;
   reg [11:0] clr;
   reg [31:0] entry;
   reg hit;
   integer i, j, n, s, t;
   wire [3:0] cond_w [0:3];
   wire [31:0] remain_w [0:3];
   wire [31:0] expect_w [0:3];
   wire [2:0] ev_w [0:3];
   wire grp = gctrl_ff[`CUB_GC_GROUP];
   wire [1:0] sa = avs_address[6:5];
   wire wr_go = avs_write & ~avs_waitrequest;
   wire [3:0] job_m1 = job_ff - 4'h1;
   wire [1:0] sj = job_m1[1:0];
   wire [15:0] nset_j = grp ? nsetw_ff[sj][31:16] : nsetw_ff[sj][15:0];
   wire [31:0] nsq = {16'h0000, neg_ff} * {16'h0000, neg_ff};
   wire [31:0] ssq = {16'h0000, nset_j} * {16'h0000, nset_j};
   wire [39:0] neg_k = {24'h000000, neg_ff} * `CUB_RATIO_SCALE;
   wire [32:0] rem_sh = {rem_ff[31:0], quo_ff[31]};
   wire rem_ge = rem_sh >= {1'b0, dvs_ff};
   wire [31:0] quo_nx = {quo_ff[30:0], rem_ge};
   // loading check covers every phase and the positive sequence itself
   wire load_ok = (pa_ff >= minload_ff) & (pb_ff >= minload_ff) & (pc_ff >= minload_ff) &
      (pos_ff >= minload_ff);

   // byte-lane merge for register writes
   function [31:0] be_merge(input [31:0] old, input [31:0] wd, input [3:0] be);
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            be_merge[k*8 +: 8] = be[k] ? wd[k*8 +: 8] : old[k*8 +: 8];
      end
   endfunction

   // merged write words, cut on purpose to each narrow field
   wire [31:0] sctrl_wr = be_merge({28'h0, sctrl_ff[sa]}, avs_writedata, avs_byteenable);
   wire [31:0] gctrl_wr = be_merge({29'h0, gctrl_ff}, avs_writedata, avs_byteenable);
   wire [31:0] minload_wr = be_merge({16'h0000, minload_ff}, avs_writedata, avs_byteenable);

   // ---------------------------------------------------------------
   // stages
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : stg
         cub_stage u_stage (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .tick(eval_ff),
            .ratio_mode(gctrl_ff[`CUB_GC_RATIO]),
            .block_in(blk_ff[g]),
            .force_en(gctrl_ff[`CUB_GC_FORCE]),
            .force_sel(sctrl_ff[g][3:2]),
            .time_mode(sctrl_ff[g][1:0]),
            .nset(grp ? nsetw_ff[g][31:16] : nsetw_ff[g][15:0]),
            .rset(grp ? rsetw_ff[g][31:16] : rsetw_ff[g][15:0]),
            .delay(delay_ff[g]),
            .inv_time(invt_ff[g]),
            .load_ok(load_ok),
            .neg(neg_ff),
            .pos(pos_ff),
            .start_ff(stage_start[g]),
            .trip_ff(stage_trip[g]),
            .blocked_ff(stage_blocked[g]),
            .cond_ff(cond_w[g]),
            .remain_ff(remain_w[g]),
            .expect_ff(expect_w[g]),
            .ev_ff(ev_w[g])
         );
      end
   endgenerate

   // time base and input capture; the stages evaluate one cycle after capture
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt_ff <= 20'h00000;
         tick_ff <= 1'b0;
         eval_ff <= 1'b0;
         stamp_ff <= 12'h000;
         {pos_ff, neg_ff, zero_ff, pang_ff, nang_ff, zang_ff} <= 96'h0;
         {pa_ff, pb_ff, pc_ff} <= 48'h0;
         blk_ff <= 4'h0;
      end else begin
         tick_ff <= (div_cnt_ff == TICK_CYCLES - 20'h00001);
         div_cnt_ff <= (div_cnt_ff == TICK_CYCLES - 20'h00001) ? 20'h00000 :
            div_cnt_ff + 20'h00001;
         eval_ff <= tick_ff;
         if (tick_ff) begin
            stamp_ff <= stamp_ff + 12'h001;
            pos_ff <= posseq_magnitude;
            neg_ff <= negseq_magnitude;
            zero_ff <= zeroseq_magnitude;
            pang_ff <= posseq_angle;
            nang_ff <= negseq_angle;
            zang_ff <= zeroseq_angle;
            pa_ff <= phase_a_fundamental;
            pb_ff <= phase_b_fundamental;
            pc_ff <= phase_c_fundamental;
            blk_ff <= block_in;
         end
      end
   end

   // ---------------------------------------------------------------
   // shared serial divider: job 0 ratio, 1-4 meas/set, 5-8 inverse time
   // ---------------------------------------------------------------
   always @* begin
      dvd = 32'h0;
      dvs = 32'h0;
      if (job_ff == 4'h0) begin
         dvd = neg_k[31:0];
         dvs = {16'h0000, pos_ff};
      end else if (job_ff < 4'h5) begin
         dvd = {16'h0000, neg_ff} * 32'h00000064;
         dvs = {16'h0000, nset_j};
      end else begin
         dvd = delay_ff[sj];
         dvs = (nsq > ssq) ? nsq - ssq : 32'h0;
      end
   end

   // one job is a load cycle and 32 shift steps; a zero divisor saturates
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_ff <= 1'b0;
         load_ff <= 1'b0;
         job_ff <= 4'h0;
         bit_ff <= 6'h00;
         rem_ff <= 33'h0;
         quo_ff <= 32'h0;
         dvs_ff <= 32'h0;
         ratio_ff <= 32'h0;
         for (i = 0; i < 4; i = i + 1) begin
            mset_ff[i] <= 32'h0;
            invt_ff[i] <= 32'hFFFFFFFF;
         end
      end else if (eval_ff) begin
         busy_ff <= 1'b1;
         load_ff <= 1'b1;
         job_ff <= 4'h0;
      end else if (busy_ff && load_ff) begin
         rem_ff <= 33'h0;
         quo_ff <= dvd;
         dvs_ff <= dvs;
         bit_ff <= 6'h00;
         load_ff <= 1'b0;
      end else if (busy_ff) begin
         rem_ff <= rem_ge ? rem_sh - {1'b0, dvs_ff} : rem_sh;
         quo_ff <= quo_nx;
         bit_ff <= bit_ff + 6'h01;
         if (bit_ff == `CUB_LAST_BIT) begin
            if (job_ff == 4'h0)
               ratio_ff <= (dvs_ff == 32'h0) ? 32'hFFFFFFFF : quo_nx;
            else if (job_ff < 4'h5)
               mset_ff[sj] <= (dvs_ff == 32'h0) ? 32'hFFFFFFFF : quo_nx;
            else
               invt_ff[sj] <= (dvs_ff == 32'h0) ? 32'hFFFFFFFF : quo_nx;
            load_ff <= 1'b1;
            busy_ff <= (job_ff != 4'h8);
            job_ff <= job_ff + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // event log: pending on-events drain one per cycle, lowest first
   // ---------------------------------------------------------------
   always @* begin
      clr = 12'h000;
      entry = 32'h0;
      hit = 1'b0;
      for (s = 3; s >= 0; s = s - 1) begin
         for (t = 2; t >= 0; t = t - 1) begin
            if (pend_ff[s*3+t]) begin
               hit = 1'b1;
               clr = 12'h001 << (s*3+t);
               entry = {neg_ff, stamp_ff, s[1:0], t[1:0] + 2'h1};
            end
         end
      end
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_ff <= 12'h000;
         wp_ff <= 4'h0;
         lcnt_ff <= 4'h0;
         fang0_ff <= 32'h0;
         fang1_ff <= 32'h0;
         for (j = 0; j < 12; j = j + 1)
            log_ff[j] <= 32'h0;
      end else begin
         // a new event in the draining cycle is kept, set beats clear
         pend_ff <= (pend_ff & ~clr) | {ev_w[3], ev_w[2], ev_w[1], ev_w[0]};
         if (hit) begin
            log_ff[wp_ff] <= entry;
            wp_ff <= (wp_ff == `CUB_LOG_DEPTH - 4'h1) ? 4'h0 : wp_ff + 4'h1;
            if (lcnt_ff != `CUB_LOG_DEPTH)
               lcnt_ff <= lcnt_ff + 4'h1;
            fang0_ff <= {nang_ff, pang_ff};
            fang1_ff <= {zang_ff, zero_ff};
         end
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then answer
   // ---------------------------------------------------------------
   always @* begin
      rdata = 32'h0;
      if (avs_address[7]) begin
         case (avs_address[4:2])
            `CUB_W_SCTRL: rdata = {28'h0, sctrl_ff[sa]};
            `CUB_W_NSET: rdata = nsetw_ff[sa];
            `CUB_W_RSET: rdata = rsetw_ff[sa];
            `CUB_W_DELAY: rdata = delay_ff[sa];
            `CUB_W_STATUS: rdata = {28'h0, cond_w[sa]};
            `CUB_W_REMAIN: rdata = remain_w[sa];
            `CUB_W_EXPECT: rdata = expect_w[sa];
            default: rdata = mset_ff[sa];
         endcase
      end else if (avs_address[6]) begin
         if (avs_address[5:2] < `CUB_LOG_DEPTH)
            rdata = log_ff[avs_address[5:2]];
      end else begin
         case (avs_address[7:2])
            `CUB_A_GCTRL: rdata = {29'h0, gctrl_ff};
            `CUB_A_MINLOAD: rdata = {16'h0000, minload_ff};
            `CUB_A_RATIO: rdata = ratio_ff;
            `CUB_A_LOGPTR: rdata = {24'h0, lcnt_ff, wp_ff};
            `CUB_A_FANG0: rdata = fang0_ff;
            `CUB_A_FANG1: rdata = fang1_ff;
            default: rdata = 32'h0;
         endcase
      end
   end

   // settings are plain registers; group only picks which pick-up half is used
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         gctrl_ff <= 3'h0;
         minload_ff <= `CUB_RST_MINLOAD;
         for (n = 0; n < 4; n = n + 1) begin
            sctrl_ff[n] <= 4'h0;
            nsetw_ff[n] <= {`CUB_RST_NSET, `CUB_RST_NSET};
            rsetw_ff[n] <= {`CUB_RST_RSET, `CUB_RST_RSET};
            delay_ff[n] <= `CUB_RST_DELAY;
         end
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest)
            avs_readdata <= rdata;
         if (wr_go && avs_address[7]) begin
            case (avs_address[4:2])
               `CUB_W_SCTRL: sctrl_ff[sa] <= sctrl_wr[3:0];
               `CUB_W_NSET: nsetw_ff[sa] <= be_merge(nsetw_ff[sa], avs_writedata, avs_byteenable);
               `CUB_W_RSET: rsetw_ff[sa] <= be_merge(rsetw_ff[sa], avs_writedata, avs_byteenable);
               `CUB_W_DELAY: delay_ff[sa] <= be_merge(delay_ff[sa], avs_writedata, avs_byteenable);
               default: ;
            endcase
         end else if (wr_go && avs_address[7:2] == `CUB_A_GCTRL) begin
            gctrl_ff <= gctrl_wr[2:0];
         end else if (wr_go && avs_address[7:2] == `CUB_A_MINLOAD) begin
            minload_ff <= minload_wr[15:0];
         end
      end
   end
endmodule // cub_top

// >>> tb/cub_checker.sv
// cub_checker.sv: bus and stage output assertions for the unbalance stages
`timescale 1ns/10ps
module cub_checker #(
   parameter [19:0] TICK_CYCLES = 20'h7A120
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire [3:0] stage_start,
   input wire [3:0] stage_trip,
   input wire [3:0] stage_blocked
);
   reg [19:0] wcnt_ff;
   reg [19:0] ccnt_ff;
   reg [11:0] outs_ff;
   wire [11:0] outs = {stage_start, stage_trip, stage_blocked};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ages of last write and last output change; a write may force outputs off the tick
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wcnt_ff <= 20'hFFFFF;
         ccnt_ff <= 20'hFFFFF;
         outs_ff <= 12'h000;
      end else begin
         wcnt_ff <= avs_write ? 20'h00000 : wcnt_ff + {19'h00000, ~&wcnt_ff};
         ccnt_ff <= (outs != outs_ff) ? 20'h00000 : ccnt_ff + {19'h00000, ~&ccnt_ff};
         outs_ff <= outs;
      end
   end
   property p_wait_once; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_once: assert property (p_wait_once) else $error("wait low too long");
   property p_wait_take;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_take: assert property (p_wait_take) else $error("request not answered");
   property p_rdata; $changed(avs_readdata) |-> !avs_waitrequest; endproperty
   a_rdata: assert property (p_rdata) else $error("readdata moved idle");
   property p_trip_start; (stage_trip & ~stage_start) == 4'h0; endproperty
   a_trip_start: assert property (p_trip_start) else $error("trip without start");
   property p_blk_excl; (stage_blocked & (stage_start | stage_trip)) == 4'h0; endproperty
   a_blk_excl: assert property (p_blk_excl) else $error("blocked with start");
   // without writes, two output changes are whole ticks apart
   property p_tick_pace; (outs != outs_ff) && (wcnt_ff > ccnt_ff + 4)
      |-> ccnt_ff >= TICK_CYCLES - 20'h00001; endproperty
   a_tick_pace: assert property (p_tick_pace) else $error("change off tick");
   property p_via_normal;
      wcnt_ff > 5 |-> (stage_blocked & ~$past(stage_blocked) & $past(stage_start)) == 4'h0;
   endproperty
   a_via_normal: assert property (p_via_normal) else $error("start to blocked");
   property p_trip_drop; wcnt_ff > 5 |-> ($past(stage_trip) & ~stage_trip & stage_start) == 4'h0;
   endproperty
   a_trip_drop: assert property (p_trip_drop) else $error("trip fell to start");
   c_trip: cover property (stage_trip != 4'h0);
   c_blocked: cover property (stage_blocked != 4'h0);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule // cub_checker

bind cub_top cub_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk, .sys_rst, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .stage_start, .stage_trip, .stage_blocked);

// >>> tb/cub_meas_model.sv
// cub_meas_model.sv: measurement subsystem and blocking matrix feeding the stages
`timescale 1ns/10ps
module cub_meas_model #(
   parameter int PERIOD = 400
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [147:0] req,
   output reg [147:0] meas_ff
);
   int cnt_ff;
   // one fresh sample set per period, held in between like a measurement frame
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= 0;
         meas_ff <= '0;
      end else begin
         cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
         if (cnt_ff == PERIOD - 1) begin
            meas_ff <= req;
         end
      end
   end
endmodule // cub_meas_model

// >>> tb/current_unbalance_protection_test.sv
// current_unbalance_protection_test.sv: self-checking bench of the four unbalance stages
`timescale 1ns/10ps
module current_unbalance_protection_test;
   localparam int TK = 400;
   logic sys_clk = 0;
   logic sys_rst = 1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 0;
   logic avs_write = 0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest;
   logic [147:0] req = 0, m;
   logic [3:0] st, tr, bl;
   integer seed = 32'hF2E02A5C;
   int miscompares = 0, comparisons = 0, neg = 0, pos = 50, phc = 50, gc = 0, blkm = 0;
   int q[4], sc[4], age[4], dl[4];
   always #5 sys_clk = !sys_clk;
   cub_meas_model #(.PERIOD(TK)) u_meas (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
      .meas_ff(m));
   cub_top #(.TICK_CYCLES(20'h00190)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .posseq_magnitude(m[15:0]),
      .negseq_magnitude(m[31:16]), .zeroseq_magnitude(m[47:32]), .posseq_angle(m[63:48]),
      .negseq_angle(m[79:64]), .zeroseq_angle(m[95:80]), .phase_a_fundamental(m[111:96]),
      .phase_b_fundamental(m[127:112]), .phase_c_fundamental(m[143:128]),
      .block_in(m[147:144]), .stage_start(st), .stage_trip(tr), .stage_blocked(bl));
   // one transfer, raised after an edge and held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(posedge sys_clk);
   endtask
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
      bus(0, a, 32'h0);
      cmp(nm, e, rd);
   endtask
   // deliver inputs, let four ticks pass, step the reference stages and compare
   task automatic settle(string nm);
      logic [11:0] e;
      int v, l;
      e = 0;
      req <= {4'(blkm), 16'(phc), 16'(pos), 16'(pos), 32'($random(seed)),
         32'($random(seed)), 16'(neg), 16'(pos)};
      repeat (4 * TK) @(posedge sys_clk);
      for (int s = 0; s < 4; s++) begin
         v = gc[0] ? neg * 10000 : neg;
         l = gc[0] ? 2000 * pos : (gc[2] && s == 0 ? 48 : 20);
         if (!((v > l && !(gc[0] && (phc < 10 || pos < 10))) || (q[s] != 0 && v * 100 >= 97 * l)))
            q[s] = 0;
         else if (q[s] != 2)
            q[s] = blkm[s] ? 3 : ((sc[s] & 3) == 0 || age[s] >= dl[s] - 3 ? 2 : 1);
         age[s] = (q[s] == 1 || q[s] == 2) ? age[s] + 4 : 0;
         v = gc[1] ? sc[s] >> 2 : q[s];
         e |= {4'(v == 1 || v == 2) << s, 4'(v == 2) << s, 4'(v == 3) << s};
      end
      cmp(nm, 32'(e), 32'({st, tr, bl}));
      rchk("status0", 8'h90, 32'h1 << (gc[1] ? sc[0] >> 2 : q[0]));
      $display("test done: %s", nm);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog well beyond the roughly 30k cycles of the sequence
   initial begin
      repeat (80000) @(posedge sys_clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 0;
      @(posedge sys_clk);
      rchk("gctrl", 8'h00, 32'h0);
      rchk("nset", 8'h84, 32'h00140014);
      rchk("rset", 8'hA8, 32'h07D007D0);
      rchk("sctrl", 8'hE0, 32'h0);
      bus(1, 8'h3C, 32'h5A5A5A5A);
      rchk("unmapped", 8'h3C, 32'h0);
      neg = 21;
      settle("instant");
      rchk("logptr", 8'h0C, 32'h88);
      rchk("mset", 8'h9C, 32'h69);
      neg = 20;
      settle("hold");
      neg = 19;
      settle("release");
      sc[1] = 1;
      bus(1, 8'hA0, 32'h1);
      bus(1, 8'hAC, 32'h9);
      sc[2] = 2;
      dl = '{0, 9, 100 / (21 * 21 - 20 * 20), 0};
      bus(1, 8'hC0, 32'h2);
      neg = 21;
      settle("fixed start");
      rchk("remain", 8'hB4, 32'(dl[1] - age[1] + 1));
      rchk("expect", 8'hD8, 32'(dl[2]));
      blkm = 2;
      settle("late block");
      blkm = 0;
      repeat (3) settle("fixed run");
      neg = 0;
      settle("clear");
      sc[2] = 0;
      bus(1, 8'hC0, 32'h0);
      gc = 1;
      bus(1, 8'h00, 32'h1);
      neg = 15;
      phc = 5;
      settle("low load");
      phc = 50;
      settle("ratio");
      rchk("ratio", 8'h08, 32'hBB8);
      neg = 0;
      settle("ratio off");
      gc = 4;
      bus(1, 8'h00, 32'h4);
      bus(1, 8'h84, 32'h00300014);
      neg = 30;
      settle("group one");
      neg = 0;
      gc = 2;
      bus(1, 8'h00, 32'h2);
      for (int f = 0; f < 4; f++) begin
         sc[3] = f << 2;
         bus(1, 8'hE0, 32'(f << 2));
         settle("forced");
      end
      gc = 0;
      bus(1, 8'h00, 32'h0);
      settle("force off");
      tally_and_finish();
   end
endmodule // current_unbalance_protection_test
